// ---- logic/term_ctrl_pkg.sv ----
`default_nettype none
package term_ctrl_pkg;

  // Clock and ramp timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RAMP_MIN_PS   = 1500;
  localparam int RAMP_MAX_PS   = 3500;
  localparam int RAMP_MIN_CYC_RAW = (RAMP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAMP_MAX_CYC_RAW = RAMP_MAX_PS / CLK_PERIOD_PS;
  localparam int RAMP_MIN_CYC  = (RAMP_MIN_CYC_RAW < 1) ? 1 : RAMP_MIN_CYC_RAW;
  localparam int RAMP_MAX_CYC  = (RAMP_MAX_CYC_RAW < 1) ? 1 : RAMP_MAX_CYC_RAW;
  // Action cycle after latency expiry: onset no earlier than min; one 4 ns clock here, later than the 3.5 ns max
  localparam int RAMP_CYC      = (RAMP_MIN_CYC > RAMP_MAX_CYC) ? RAMP_MIN_CYC : RAMP_MAX_CYC;
  localparam logic [5:0] RAMP_CYC_W = 6'(RAMP_CYC);

  // Burst length 32 extension of the off latency
  localparam logic [5:0] BL32_EXTRA = 6'h08;

  // Latency tables, index = frequency bin 0..7, zero means undefined
  localparam logic [7:0][5:0] ON_LAT_A  = {6'h08, 6'h06, 6'h06, 6'h04, 6'h04, 6'h00, 6'h00, 6'h00};
  localparam logic [7:0][5:0] ON_LAT_B  = {6'h18, 6'h14, 6'h12, 6'h0E, 6'h0C, 6'h06, 6'h00, 6'h00};
  localparam logic [7:0][5:0] OFF_LAT_A = {6'h1C, 6'h1A, 6'h18, 6'h16, 6'h14, 6'h00, 6'h00, 6'h00};
  localparam logic [7:0][5:0] OFF_LAT_B = {6'h2C, 6'h28, 6'h24, 6'h20, 6'h1C, 6'h16, 6'h00, 6'h00};

  // Termination value field codes
  localparam logic [2:0] TERM_CODE_OFF = 3'h0;
  localparam logic [2:0] TERM_CODE_240 = 3'h1;
  localparam logic [2:0] TERM_CODE_120 = 3'h2;
  localparam logic [2:0] TERM_CODE_80  = 3'h3;
  localparam logic [2:0] TERM_CODE_60  = 3'h4;
  localparam logic [2:0] TERM_CODE_48  = 3'h5;
  localparam logic [2:0] TERM_CODE_40  = 3'h6;

  // Decoded resistance in ohms
  localparam logic [7:0] OHM_NONE = 8'h00;
  localparam logic [7:0] OHM_240  = 8'hF0;
  localparam logic [7:0] OHM_120  = 8'h78;
  localparam logic [7:0] OHM_80   = 8'h50;
  localparam logic [7:0] OHM_60   = 8'h3C;
  localparam logic [7:0] OHM_48   = 8'h30;
  localparam logic [7:0] OHM_40   = 8'h28;

  // Reset values
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic [5:0] LAT_RESET = 6'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_COUNT
  } term_state_t;

endpackage
`default_nettype wire

// ---- logic/term_latency_lut.sv ----
`timescale 1ns/1ps
`default_nettype none
module term_latency_lut (
  // Selection
  input  wire logic [2:0] freq_bin_in,
  input  wire logic       set_b_in,
  input  wire logic       burst32_in,
  // Result
  output logic      [5:0] on_lat_out,
  output logic      [5:0] off_lat_out,
  output logic            valid_out
);

  logic [5:0] on_raw;
  logic [5:0] off_raw;

  always_comb begin
    on_raw  = set_b_in ? term_ctrl_pkg::ON_LAT_B[freq_bin_in] : term_ctrl_pkg::ON_LAT_A[freq_bin_in];
    off_raw = set_b_in ? term_ctrl_pkg::OFF_LAT_B[freq_bin_in] : term_ctrl_pkg::OFF_LAT_A[freq_bin_in];
    on_lat_out  = on_raw;
    off_lat_out = burst32_in ? 6'(off_raw + term_ctrl_pkg::BL32_EXTRA) : off_raw;
    valid_out   = (on_raw != 6'h00);
  end

endmodule
`default_nettype wire

// ---- logic/dq_write_termination_control.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - With termination enabled, data pins stay unterminated when no write burst arrives.
// - A sampled Write-1 or Mask Write-1 turns termination on, no control pin.
// - After the burst, termination returns to high impedance with no further command.
// - Turn-on latency is counted in clocks from the following CAS-2 command.
// - Turn-off latency is counted in clocks from the same CAS-2 command.
// - Turn-on latency per frequency bin and set; undefined below 533 MHz.
// - Turn-off latency per frequency bin and set from the fixed table.
// - Burst length 32 adds eight clocks to the turn-off latency.
// - Termination turns on between 1.5 ns and 3.5 ns after on latency; the code turns it on one 4 ns clock after cnt reaches on_lat.
// - Termination turns off between 1.5 ns and 3.5 ns after off latency; the code turns it off one 4 ns clock after cnt reaches off_lat.
// - Write leveling: strobes terminated if enabled, nothing terminated if disabled.
// - Write leveling keeps data-pin termination off always.
// - Value field decodes 001..110 to 240, 120, 80, 60, 48, 40 ohm.
// - Selected termination applies to data, mask/inversion and both strobe pins.
// - Field zero disables termination; any non-zero value enables it.
// - Power-down and self-refresh keep data-pin termination off.
module dq_write_termination_control (
  // Clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RESET_IN,
  // Commands
  input  wire logic       WRITE_CMD_IN,
  input  wire logic       CAS2_CMD_IN,
  input  wire logic       BURST32_IN,
  // Configuration
  input  wire logic [2:0] TERM_SETTING_IN,
  input  wire logic       WRITE_LATENCY_SET_B_IN,
  input  wire logic [2:0] FREQ_BIN_IN,
  // Device modes
  input  wire logic       WRITE_LEVELING_IN,
  input  wire logic       POWER_DOWN_IN,
  input  wire logic       SELF_REFRESH_IN,
  // Termination enables
  output logic      [7:0] DQ_TERM_EN_OUT,
  output logic            DATA_MASK_INVERSION_PIN_TERM_EN_OUT,
  output logic            DQS_T_TERM_EN_OUT,
  output logic            DQS_C_TERM_EN_OUT,
  // Status
  output logic      [7:0] TERMINATION_RESISTANCE_OUT,
  output logic            LATENCY_UNDEFINED_OUT
);

  typedef struct packed {
    term_ctrl_pkg::term_state_t state;
    logic                       pend;
    logic [5:0]                 cnt;
    logic [5:0]                 on_lat;
    logic [5:0]                 off_lat;
    logic                       data_term;
    logic                       strobe_term;
    logic [7:0]                 ohm;
    logic                       undef;
  } ctrl_t;

  ctrl_t      cur_ff;
  ctrl_t      nxt_cur;
  logic [5:0] lut_on;
  logic [5:0] lut_off;
  logic       lut_valid;
  logic       term_enabled;
  logic       quiet;

  term_latency_lut u_lut (
    .freq_bin_in (FREQ_BIN_IN),
    .set_b_in    (WRITE_LATENCY_SET_B_IN),
    .burst32_in  (BURST32_IN),
    .on_lat_out  (lut_on),
    .off_lat_out (lut_off),
    .valid_out   (lut_valid)
  );

  assign term_enabled = (TERM_SETTING_IN != term_ctrl_pkg::TERM_CODE_OFF);
  assign quiet        = POWER_DOWN_IN | SELF_REFRESH_IN;

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.undef = ~lut_valid;
    unique case (TERM_SETTING_IN)
      term_ctrl_pkg::TERM_CODE_240: nxt_cur.ohm = term_ctrl_pkg::OHM_240;
      term_ctrl_pkg::TERM_CODE_120: nxt_cur.ohm = term_ctrl_pkg::OHM_120;
      term_ctrl_pkg::TERM_CODE_80:  nxt_cur.ohm = term_ctrl_pkg::OHM_80;
      term_ctrl_pkg::TERM_CODE_60:  nxt_cur.ohm = term_ctrl_pkg::OHM_60;
      term_ctrl_pkg::TERM_CODE_48:  nxt_cur.ohm = term_ctrl_pkg::OHM_48;
      term_ctrl_pkg::TERM_CODE_40:  nxt_cur.ohm = term_ctrl_pkg::OHM_40;
      default:                      nxt_cur.ohm = term_ctrl_pkg::OHM_NONE;
    endcase
    nxt_cur.strobe_term = 1'b0;
    if (quiet || !term_enabled || WRITE_LEVELING_IN) begin
      nxt_cur.state     = term_ctrl_pkg::ST_IDLE;
      nxt_cur.pend      = 1'b0;
      nxt_cur.cnt       = term_ctrl_pkg::CNT_RESET;
      nxt_cur.data_term = 1'b0;
      nxt_cur.strobe_term = WRITE_LEVELING_IN && term_enabled && !quiet;
    end else begin
      unique case (cur_ff.state)
        term_ctrl_pkg::ST_IDLE: begin
          if (WRITE_CMD_IN && lut_valid) begin
            nxt_cur.state = term_ctrl_pkg::ST_ARMED;
          end
        end
        term_ctrl_pkg::ST_ARMED: begin
          if (CAS2_CMD_IN) begin
            nxt_cur.state   = term_ctrl_pkg::ST_COUNT;
            nxt_cur.cnt     = 6'h01;
            nxt_cur.on_lat  = lut_on;
            nxt_cur.off_lat = lut_off;
          end
        end
        term_ctrl_pkg::ST_COUNT: begin
          nxt_cur.cnt = 6'(cur_ff.cnt + 6'h01);
          if (WRITE_CMD_IN && lut_valid) begin
            nxt_cur.pend = 1'b1;
          end
          if (cur_ff.cnt == 6'(cur_ff.on_lat + term_ctrl_pkg::RAMP_CYC_W - 6'h01)) begin
            nxt_cur.data_term = 1'b1;
          end
          if (cur_ff.pend && CAS2_CMD_IN) begin
            nxt_cur.pend    = 1'b0;
            nxt_cur.cnt     = 6'h01;
            nxt_cur.on_lat  = lut_on;
            nxt_cur.off_lat = lut_off;
          end else if (cur_ff.cnt == 6'(cur_ff.off_lat + term_ctrl_pkg::RAMP_CYC_W - 6'h01)) begin
            nxt_cur.data_term = 1'b0;
            nxt_cur.state     = cur_ff.pend ? term_ctrl_pkg::ST_ARMED : term_ctrl_pkg::ST_IDLE;
            nxt_cur.pend      = 1'b0;
            nxt_cur.cnt       = term_ctrl_pkg::CNT_RESET;
          end
        end
        default: begin
          nxt_cur.state = term_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cur_ff <= '{state:       term_ctrl_pkg::ST_IDLE,
                  pend:        1'b0,
                  cnt:         term_ctrl_pkg::CNT_RESET,
                  on_lat:      term_ctrl_pkg::LAT_RESET,
                  off_lat:     term_ctrl_pkg::LAT_RESET,
                  data_term:   1'b0,
                  strobe_term: 1'b0,
                  ohm:         term_ctrl_pkg::OHM_NONE,
                  undef:       1'b1};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dq
      assign DQ_TERM_EN_OUT[gi] = cur_ff.data_term;
    end
  endgenerate

  assign DATA_MASK_INVERSION_PIN_TERM_EN_OUT = cur_ff.data_term;
  assign DQS_T_TERM_EN_OUT                   = cur_ff.data_term | cur_ff.strobe_term;
  assign DQS_C_TERM_EN_OUT                   = cur_ff.data_term | cur_ff.strobe_term;
  assign TERMINATION_RESISTANCE_OUT          = cur_ff.ohm;
  assign LATENCY_UNDEFINED_OUT               = cur_ff.undef;

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  localparam logic [5:0] RAMP_CYC_W_A = term_ctrl_pkg::RAMP_CYC_W;

  logic [5:0] since_cas;
  logic       cas_seen;
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      since_cas <= 6'h00;
      cas_seen  <= 1'b0;
    end else if (cur_ff.state == term_ctrl_pkg::ST_ARMED && CAS2_CMD_IN && !quiet && term_enabled
                 && !WRITE_LEVELING_IN) begin
      since_cas <= 6'h01;
      cas_seen  <= 1'b1;
    end else if (cur_ff.state == term_ctrl_pkg::ST_COUNT && cur_ff.pend && CAS2_CMD_IN && !quiet && term_enabled
                 && !WRITE_LEVELING_IN) begin
      // Pending write restarts the count from its own CAS-2
      since_cas <= 6'h01;
    end else if (cur_ff.state != term_ctrl_pkg::ST_COUNT) begin
      cas_seen  <= 1'b0;
    end else begin
      since_cas <= 6'(since_cas + 6'h01);
    end
  end

  idle_hiz_a:      assert property (cur_ff.state == term_ctrl_pkg::ST_IDLE |-> !DQ_TERM_EN_OUT[0])
    else $error("data termination on with no burst");
  write_arms_a:    assert property (cur_ff.state == term_ctrl_pkg::ST_IDLE && WRITE_CMD_IN && lut_valid
                                    && term_enabled && !quiet && !WRITE_LEVELING_IN
                                    |=> cur_ff.state == term_ctrl_pkg::ST_ARMED)
    else $error("write command not taken");
  on_time_a:       assert property (cas_seen && !cur_ff.pend && since_cas == 6'(cur_ff.on_lat + RAMP_CYC_W_A - 6'h01)
                                    && $stable(TERM_SETTING_IN) && !quiet && !WRITE_LEVELING_IN
                                    |=> DQ_TERM_EN_OUT[0])
    else $error("termination not on at latency");
  on_not_early_a:  assert property ($rose(DQ_TERM_EN_OUT[0]) |-> cur_ff.cnt > cur_ff.on_lat)
    else $error("termination on before latency");
  off_time_a:      assert property ($fell(DQ_TERM_EN_OUT[0]) && !quiet && term_enabled && !WRITE_LEVELING_IN
                                    |-> $past(cur_ff.cnt) == 6'(cur_ff.off_lat + RAMP_CYC_W_A - 6'h01))
    else $error("termination off at wrong cycle");
  quiet_off_a:     assert property (quiet |=> !DQ_TERM_EN_OUT[0] && !DQS_T_TERM_EN_OUT)
    else $error("termination on in power-down");
  level_dq_off_a:  assert property (WRITE_LEVELING_IN |=> !DQ_TERM_EN_OUT[0])
    else $error("data termination on in leveling");
  level_dqs_a:     assert property (WRITE_LEVELING_IN && term_enabled && !quiet |=> DQS_C_TERM_EN_OUT)
    else $error("strobe not terminated in leveling");
  pins_equal_a:    assert property (DATA_MASK_INVERSION_PIN_TERM_EN_OUT == DQ_TERM_EN_OUT[7]
                                    && DQS_T_TERM_EN_OUT == DQS_C_TERM_EN_OUT)
    else $error("pin termination mismatch");
  decode_240_a:    assert property (TERM_SETTING_IN == 3'h1 |=> TERMINATION_RESISTANCE_OUT == 8'hF0)
    else $error("resistance decode wrong");
  lat_hold_a:      assert property (cur_ff.state == term_ctrl_pkg::ST_COUNT && !CAS2_CMD_IN
                                    |=> $stable(cur_ff.off_lat))
    else $error("latency changed during burst");
  bl32_ext_a:      assert property (FREQ_BIN_IN == 3'h3 && !WRITE_LATENCY_SET_B_IN && BURST32_IN
                                    |-> lut_off == 6'h1C)
    else $error("burst 32 extension wrong");

  burst_cov_c:   cover property ($rose(DQ_TERM_EN_OUT[0]) ##[1:60] $fell(DQ_TERM_EN_OUT[0]));
  back2back_c:   cover property (cur_ff.pend && CAS2_CMD_IN);
  leveling_c:    cover property (WRITE_LEVELING_IN && DQS_T_TERM_EN_OUT);
  pd_abort_c:    cover property (DQ_TERM_EN_OUT[0] && quiet);

endmodule
`default_nettype wire

// ---- dv/ctrl_cmd_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctrl_cmd_model (
  // Clock
  input  wire logic clk_in,
  // Commands
  output logic      write_out,
  output logic      cas2_out,
  output logic      burst32_out
);
  initial begin
    write_out   = 1'b0;
    cas2_out    = 1'b0;
    burst32_out = 1'b0;
  end
  // Write pulse, CAS-2 after gap idle cycles; burst length flips once sampled
  task automatic send(input int gap, input logic bl32);
    @(posedge clk_in);
    write_out <= 1'b1;
    @(posedge clk_in);
    write_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
    cas2_out    <= 1'b1;
    burst32_out <= bl32;
    @(posedge clk_in);
    cas2_out    <= 1'b0;
    burst32_out <= ~bl32;
  endtask
endmodule
`default_nettype wire

// ---- dv/dq_write_termination_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dq_write_termination_control_tb_top;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic [2:0]  setting = 3'h0;
  logic        set_b   = 1'b0;
  logic [2:0]  bin     = 3'h3;
  logic        lvl     = 1'b0;
  logic        pd      = 1'b0;
  logic        sr      = 1'b0;
  logic        wr;
  logic        cas2;
  logic        bl32;
  logic [7:0]  dq_en;
  logic        dmi_en;
  logic        dqs_t_en;
  logic        dqs_c_en;
  logic [7:0]  ohm;
  logic        undef;
  logic [10:0] en_vec;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          on_a [8] = '{0, 0, 0, 4, 4, 6, 6, 8};
  int          on_b [8] = '{0, 0, 6, 12, 14, 18, 20, 24};
  int          off_a [8] = '{0, 0, 0, 20, 22, 24, 26, 28};
  int          off_b [8] = '{0, 0, 22, 28, 32, 36, 40, 44};

  assign en_vec = {dq_en, dmi_en, dqs_t_en, dqs_c_en};

  initial begin
    forever #2 clk = ~clk;
  end

  ctrl_cmd_model CTRL (.clk_in(clk), .write_out(wr), .cas2_out(cas2), .burst32_out(bl32));

  dq_write_termination_control DUT (
    .CLK_IN(clk), .RESET_IN(rst), .WRITE_CMD_IN(wr), .CAS2_CMD_IN(cas2), .BURST32_IN(bl32),
    .TERM_SETTING_IN(setting), .WRITE_LATENCY_SET_B_IN(set_b), .FREQ_BIN_IN(bin),
    .WRITE_LEVELING_IN(lvl), .POWER_DOWN_IN(pd), .SELF_REFRESH_IN(sr),
    .DQ_TERM_EN_OUT(dq_en), .DATA_MASK_INVERSION_PIN_TERM_EN_OUT(dmi_en),
    .DQS_T_TERM_EN_OUT(dqs_t_en), .DQS_C_TERM_EN_OUT(dqs_c_en),
    .TERMINATION_RESISTANCE_OUT(ohm), .LATENCY_UNDEFINED_OUT(undef)
  );

  task automatic chk_en(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // All enables on from the on edge up to, not including, the off edge counted from CAS-2
  task automatic expect_window(input int on, input int off, input int len);
    for (int i = 1; i <= len; i++) begin
      @(posedge clk);
      #1;
      chk_en(en_vec, (i >= on && i < off) ? 11'h7FF : 11'h000);
    end
  endtask

  task automatic t_reset;
    #1;
    chk_val({7'h00, undef}, 8'h01);
    chk_en(en_vec, 11'h000);
    @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic t_decode;
    logic [7:0] tab [8];
    tab = '{8'h00, 8'hF0, 8'h78, 8'h50, 8'h3C, 8'h30, 8'h28, 8'h00};
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      setting <= 3'(c);
      repeat (2) @(posedge clk);
      #1;
      chk_val(ohm, tab[c]);
    end
  endtask

  task automatic t_latency(input logic b, input logic bl);
    int on;
    int off;
    for (int f = 0; f < 8; f++) begin
      @(posedge clk);
      set_b <= b;
      bin <= 3'(f);
      setting <= 3'h2;
      repeat (2) @(posedge clk);
      #1;
      on = b ? on_b[f] : on_a[f];
      off = (b ? off_b[f] : off_a[f]) + (bl ? 8 : 0);
      chk_val({7'h00, undef}, {7'h00, on == 0});
      CTRL.send(0, bl);
      if (on == 0) expect_window(99, 99, 30);
      else expect_window(on, off, off + 3);
    end
  endtask

  // Bin and set change right after CAS-2 must not alter the running burst
  task automatic t_hold;
    @(posedge clk);
    set_b <= 1'b0;
    bin <= 3'h3;
    CTRL.send(2, 1'b1);
    bin <= 3'h7;
    set_b <= 1'b1;
    expect_window(4, 28, 31);
  endtask

  // Second write during a burst: its CAS-2 restarts both latencies
  task automatic t_pipe;
    @(posedge clk);
    set_b <= 1'b0;
    bin <= 3'h3;
    setting <= 3'h2;
    CTRL.send(0, 1'b0);
    CTRL.send(0, 1'b0);
    expect_window(4, 20, 23);
  endtask

  // Power-down, self-refresh and a zero field each cut a live burst
  task automatic t_abort;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      set_b <= 1'b0;
      bin <= 3'h7;
      setting <= 3'h1;
      CTRL.send(0, 1'b0);
      expect_window(8, 28, 12);
      @(posedge clk);
      pd <= (k == 0);
      sr <= (k == 1);
      setting <= (k == 2) ? 3'h0 : 3'h1;
      @(posedge clk);
      #1;
      chk_en(en_vec, 11'h000);
      @(posedge clk);
      pd <= 1'b0;
      sr <= 1'b0;
      setting <= 3'h1;
      expect_window(99, 99, 20);
    end
  endtask

  task automatic t_level;
    @(posedge clk);
    lvl <= 1'b1;
    setting <= 3'h4;
    @(posedge clk);
    repeat (10) begin
      @(posedge clk);
      #1;
      chk_en(en_vec, 11'h003);
    end
    @(posedge clk);
    setting <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
    chk_en(en_vec, 11'h000);
    @(posedge clk);
    lvl <= 1'b0;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    t_reset();
    t_decode();
    t_latency(1'b0, 1'b0);
    t_latency(1'b0, 1'b1);
    t_latency(1'b1, 1'b0);
    t_latency(1'b1, 1'b1);
    t_hold();
    t_pipe();
    t_abort();
    t_level();
    conclude();
  end
endmodule
`default_nettype wire
